// *** tbg_pkg.sv ***
`default_nettype none
package tbg_pkg;
    // blocking mode encodings
    localparam logic [1:0] MODE_ONCE = 2'h0;
    localparam logic [1:0] MODE_WINDOW = 2'h1;
    localparam logic [1:0] MODE_WINDOW_INV = 2'h2;
    localparam logic [1:0] MODE_GATE = 2'h3;
    // blocker source selector encodings
    localparam logic [1:0] BSRC_FRONT_EVENT = 2'h0;
    localparam logic [1:0] BSRC_SYNC = 2'h1;
    localparam logic [1:0] BSRC_OTHER0 = 2'h2;
    localparam logic [1:0] BSRC_OTHER1 = 2'h3;
    // data clock rate and default widths
    localparam int DATA_CLK_MHZ = 250;
    localparam int WIN_LEN_W = 32;
    localparam int PULSE_CNT_W = 32;
    // reset values
    localparam logic [1:0] MODE_RST = MODE_ONCE;
    localparam logic [1:0] BSRC_RST = BSRC_SYNC;
endpackage : tbg_pkg
`default_nettype wire

// *** tbg_sync_edge.sv ***
`default_nettype none
// two-stage synchroniser with rising-edge pulse
module tbg_sync_edge (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // raw level in
    input wire logic async_i,
    // synchronised level and its rising edge
    output logic level_o,
    output logic rise_o
);
    logic meta; // first stage, read by the second stage only
    logic stage2; // settled level
    logic stage3; // delayed copy for edge detection

    // chain of three flops; only stage2 and stage3 feed logic
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            meta <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            meta <= async_i;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    assign level_o = stage2;
    assign rise_o = stage2 & ~stage3;
endmodule : tbg_sync_edge
`default_nettype wire

// *** tbg_gate.sv ***
`default_nettype none
// Behaviour
// - unconfigured unit passes every trigger unchanged
// - blocker pulses ignored while blocker unarmed
// - arming triggers enables path, still blocked
// - separate arm enables release by blocker
// - once mode: blocked until first blocker event
// - window mode passes triggers inside window
// - inverted window rejects triggers inside window
// - gate mode passes only while blocker high
// - blocker source selectable among trigger sources
// - non-front-panel timing resolved at 250 MHz
// - blocker pulses counted and readable
module tbg_gate
    import tbg_pkg::*;
#(
    parameter int WIN_W = WIN_LEN_W,
    parameter int CNT_W = PULSE_CNT_W
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // host commands, one-cycle pulses
    input wire logic configure_event_blocker_cmd_i,
    input wire logic arm_event_blocker_cmd_i,
    input wire logic disarm_event_blocker_cmd_i,
    input wire logic arm_acquisition_events_cmd_i,
    input wire logic disarm_acquisition_events_cmd_i,
    input wire logic read_blocker_pulse_count_cmd_i,
    // configuration, sampled by the configure command
    input wire logic [1:0] cfg_mode_i,
    input wire logic [1:0] cfg_blocker_src_i,
    input wire logic [WIN_W-1:0] cfg_window_len_i,
    // trigger path and blocker candidates
    input wire logic front_panel_event_input_pulse_i,
    input wire logic front_panel_event_input_i,
    input wire logic sync_input_i,
    input wire logic [1:0] other_src_i,
    // outputs
    output logic front_panel_event_input_pulse_o,
    output logic blocking_active_o,
    output logic blocker_armed_o,
    output logic pass_open_o,
    output logic [CNT_W-1:0] blocker_pulse_count_o,
    output logic count_valid_o
);
    // one-hot control states
    // released is a state of its own so a disarm can clear once-mode history
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,    // not configured: free pass
        ST_BLOCKED = 4'h2, // configured, blocker not armed
        ST_ARMED = 4'h4,   // waiting for/acting on blocker events
        ST_RELEASED = 4'h8 // once mode after its event
    } tbg_state_t;

    tbg_state_t state, next_state;
    logic [1:0] mode; // latched mode
    logic [1:0] bsrc; // latched blocker source
    logic [WIN_W-1:0] win_len; // latched window length
    logic [WIN_W-1:0] win_cnt; // remaining window cycles
    logic acq_armed; // trigger reception enabled
    logic [CNT_W-1:0] pulse_cnt; // blocker event count
    logic raw_blk; // selected blocker level, unsynchronised
    logic blk_level; // synchronised blocker level
    logic blk_rise; // synchronised blocker rising edge
    logic win_open; // window currently running
    logic pass_now; // combined pass decision

    // source selection over the blocker candidates
    // the mux sits before the synchroniser, so a reconfigure while the
    // selected level is high can show up as one extra blocker edge;
    // hosts should change the source only while the blocker is idle
    function automatic logic sel_src(input logic [1:0] s, input logic fp, input logic sy, input logic [1:0] ot);
        unique case (s)
            BSRC_FRONT_EVENT: sel_src = fp;
            BSRC_SYNC: sel_src = sy;
            BSRC_OTHER0: sel_src = ot[0];
            BSRC_OTHER1: sel_src = ot[1];
        endcase
    endfunction : sel_src

    assign raw_blk = sel_src(bsrc, front_panel_event_input_i, sync_input_i, other_src_i);

    // sync input resolved on the 250 MHz data clock
    // two flops of delay, edge flagged with the new level: a blocker edge shows two cycles after the pin
    tbg_sync_edge u_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .async_i(raw_blk),
        .level_o(blk_level),
        .rise_o(blk_rise)
    );

    // a zero length never opens the window: an edge loads zero and the
    // counter stays idle, which the inverted mode reads as always passing
    assign win_open = (win_cnt != '0);

    // pass decision: configured units pass nothing until armed; once mode also waits for release
    // gate and window modes also need trigger reception armed; the idle
    // state passes regardless so an unconfigured unit behaves as a wire
    always_comb begin
        pass_now = 1'b0;
        unique case (state)
            ST_IDLE: pass_now = 1'b1;
            ST_BLOCKED: pass_now = 1'b0;
            ST_RELEASED: pass_now = acq_armed;
            ST_ARMED: begin
                unique case (mode)
                    MODE_ONCE: pass_now = 1'b0;
                    MODE_WINDOW: pass_now = acq_armed & win_open;
                    MODE_WINDOW_INV: pass_now = acq_armed & ~win_open;
                    MODE_GATE: pass_now = acq_armed & blk_level;
                endcase
            end
            default: pass_now = 1'b0;
        endcase
    end

    // state transitions; configure from any state re-blocks
    // disarm outranks a blocker edge in the same cycle, so a release
    // racing the host command never leaves the unit released
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (configure_event_blocker_cmd_i) next_state = ST_BLOCKED;
            ST_BLOCKED: if (arm_event_blocker_cmd_i) next_state = ST_ARMED;
            ST_ARMED: begin
                if (disarm_event_blocker_cmd_i) next_state = ST_BLOCKED;
                else if (mode == MODE_ONCE && blk_rise) next_state = ST_RELEASED;
            end
            ST_RELEASED: begin
                if (disarm_event_blocker_cmd_i) next_state = ST_BLOCKED;
            end
            default: next_state = ST_IDLE;
        endcase
        if (configure_event_blocker_cmd_i && state != ST_IDLE) next_state = ST_BLOCKED;
    end

    // state and configuration registers
    // configuration is latched only by the command, so inputs may move between commands
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            mode <= MODE_RST;
            bsrc <= BSRC_RST;
            win_len <= '0;
        end else begin
            state <= next_state;
            if (configure_event_blocker_cmd_i) begin
                mode <= cfg_mode_i;
                bsrc <= cfg_blocker_src_i;
                win_len <= cfg_window_len_i;
            end
        end
    end

    // acquisition arm flag; arm wins over disarm
    // a host that pulses both in one cycle keeps reception on
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) acq_armed <= 1'b0;
        else if (arm_acquisition_events_cmd_i) acq_armed <= 1'b1;
        else if (disarm_acquisition_events_cmd_i) acq_armed <= 1'b0;
    end

    // window counter in data clock cycles; an edge restarts it
    // retriggering restarts the full length rather than extending it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) win_cnt <= '0;
        else if (state != ST_ARMED) win_cnt <= '0;
        else if (blk_rise) win_cnt <= win_len;
        else if (win_open) win_cnt <= win_cnt - 1'b1;
    end

    // blocker pulse counter, only armed edges count; saturates
    // never cleared by the host, so activity is judged by two reads;
    // saturation keeps a long run from wrapping back to a small value
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) pulse_cnt <= '0;
        else if (blk_rise && (state == ST_ARMED || state == ST_RELEASED) && ~&pulse_cnt)
            pulse_cnt <= pulse_cnt + 1'b1;
    end

    // registered outputs; trigger costs one cycle of latency
    // blocking and armed status outputs follow next_state so they change with the state flop
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            front_panel_event_input_pulse_o <= 1'b0;
            blocking_active_o <= 1'b0;
            blocker_armed_o <= 1'b0;
            pass_open_o <= 1'b1;
            blocker_pulse_count_o <= '0;
            count_valid_o <= 1'b0;
        end else begin
            front_panel_event_input_pulse_o <= front_panel_event_input_pulse_i & pass_now;
            blocking_active_o <= (next_state != ST_IDLE);
            blocker_armed_o <= (next_state == ST_ARMED) || (next_state == ST_RELEASED);
            pass_open_o <= pass_now;
            count_valid_o <= read_blocker_pulse_count_cmd_i;
            if (read_blocker_pulse_count_cmd_i) blocker_pulse_count_o <= pulse_cnt;
        end
    end

    // checks; each one names the rule it guards and stays quiet in reset
    // internal state is watched directly so a failure points at the flop
    // that went wrong rather than at a late output
    sequence s_armed_rise;
        state == ST_ARMED && blk_rise && !disarm_event_blocker_cmd_i && !configure_event_blocker_cmd_i;
    endsequence

    idle_pass_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_IDLE |=> front_panel_event_input_pulse_o == $past(front_panel_event_input_pulse_i)) else $error("idle trigger not passed");
    unarmed_block_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_BLOCKED |=> !front_panel_event_input_pulse_o) else $error("trigger passed while unarmed");
    arm_path_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !acq_armed && state != ST_IDLE |=> !front_panel_event_input_pulse_o) else $error("trigger passed without reception");
    arm_cmd_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_BLOCKED && !arm_event_blocker_cmd_i |=> state != ST_ARMED && state != ST_RELEASED)
        else $error("release without arm");
    once_release_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_armed_rise and mode == MODE_ONCE |=> state == ST_RELEASED) else $error("once mode not released");
    window_open_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_armed_rise and win_len != '0 |=> win_cnt == $past(win_len)) else $error("window not opened");
    window_inv_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_ARMED && mode == MODE_WINDOW_INV && win_open |=> !front_panel_event_input_pulse_o)
        else $error("trigger passed inside inverted window");
    gate_follow_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_ARMED && mode == MODE_GATE && acq_armed |=> front_panel_event_input_pulse_o == $past(front_panel_event_input_pulse_i & blk_level))
        else $error("gate does not follow blocker");
    count_step_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_armed_rise and !(&pulse_cnt) |=> pulse_cnt == $past(pulse_cnt) + 1'b1) else $error("pulse not counted");
    disarm_back_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_RELEASED && disarm_event_blocker_cmd_i && !configure_event_blocker_cmd_i |=> state == ST_BLOCKED)
        else $error("disarm did not re-block");

    // blocker path: selected candidate, two flops late, one-cycle edge
    sequence s_level_up;
        !blk_level ##1 blk_level;
    endsequence
    src_select_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        raw_blk == ((bsrc == BSRC_FRONT_EVENT) ? front_panel_event_input_i :
            (bsrc == BSRC_SYNC) ? sync_input_i : other_src_i[bsrc[0]]))
        else $error("blocker source not selected");
    sync_delay_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !$past(srst_i) && !$past(srst_i, 2) |-> blk_level == $past(raw_blk, 2))
        else $error("blocker level not two cycles late");
    edge_detect_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_level_up |-> blk_rise) else $error("blocker edge missed");
    rise_level_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        blk_rise |-> blk_level && !$past(blk_level)) else $error("edge without a new level");

    // arming steps, each taken on one clock edge
    sequence s_arm_cmd;
        state == ST_BLOCKED && arm_event_blocker_cmd_i && !configure_event_blocker_cmd_i;
    endsequence
    sequence s_disarm_cmd;
        state == ST_ARMED && disarm_event_blocker_cmd_i && !configure_event_blocker_cmd_i;
    endsequence
    arm_enter_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_arm_cmd |=> state == ST_ARMED && blocker_armed_o) else $error("arm command ignored");
    disarm_armed_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_disarm_cmd |=> state == ST_BLOCKED && !blocker_armed_o)
        else $error("disarm ignored while armed");
    config_reblock_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        configure_event_blocker_cmd_i |=> state == ST_BLOCKED && blocking_active_o)
        else $error("configure did not block");

    // trigger flow in each mode
    sequence s_window_running;
        state == ST_ARMED && mode == MODE_WINDOW && acq_armed && win_open;
    endsequence
    window_pass_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_window_running |=> front_panel_event_input_pulse_o == $past(front_panel_event_input_pulse_i))
        else $error("trigger dropped inside window");
    window_closed_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_ARMED && mode == MODE_WINDOW && !win_open |=> !front_panel_event_input_pulse_o)
        else $error("trigger passed outside window");
    inv_outside_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_ARMED && mode == MODE_WINDOW_INV && acq_armed && !win_open
            |=> front_panel_event_input_pulse_o == $past(front_panel_event_input_pulse_i)) else $error("inverted window dropped outside trigger");
    once_block_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_ARMED && mode == MODE_ONCE |=> !front_panel_event_input_pulse_o)
        else $error("trigger passed before release");
    released_pass_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_RELEASED && acq_armed |=> front_panel_event_input_pulse_o == $past(front_panel_event_input_pulse_i))
        else $error("released unit dropped a trigger");
    gate_closed_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_ARMED && mode == MODE_GATE && !blk_level |=> !front_panel_event_input_pulse_o)
        else $error("trigger passed with gate shut");
    no_spurious_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        front_panel_event_input_pulse_o |-> $past(front_panel_event_input_pulse_i)) else $error("trigger out without trigger in");

    // counters and status
    window_count_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_ARMED && !blk_rise && win_open |=> win_cnt == $past(win_cnt) - 1'b1)
        else $error("window not counted down");
    count_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_IDLE || state == ST_BLOCKED |=> pulse_cnt == $past(pulse_cnt))
        else $error("pulse counted while unarmed");
    count_snap_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        read_blocker_pulse_count_cmd_i |=> count_valid_o && blocker_pulse_count_o == $past(pulse_cnt))
        else $error("count snapshot wrong");
    pass_flag_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state == ST_IDLE |=> pass_open_o) else $error("idle unit shows blocked");
endmodule : tbg_gate
`default_nettype wire

// *** tbg_blk_model.sv ***
`default_nettype none
// far-side source of the shared blocker level
module tbg_blk_model (
    // clock
    input wire logic sys_clk_i,
    // request: raise level for hold_i cycles
    input wire logic fire_i,
    input wire logic [7:0] hold_i,
    // one level shared by every unit
    output logic blk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int left = 0; // cycles still high
    // request taken on the rising edge
    always @(posedge sys_clk_i) begin
        if (fire_i) left <= hold_i;
        else if (left > 0) left <= left - 1;
    end
    // level moves on the falling edge, idle low
    always @(negedge sys_clk_i) blk_o <= (left != 0);
endmodule : tbg_blk_model
`default_nettype wire

// *** trigger_blocking_gate_tb_top.sv ***
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %0d got %0d", nm, e, g); end end
module trigger_blocking_gate_tb_top import tbg_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    // stimulus
    logic clk = 0, srst = 1, cfg_c = 0, arm_b = 0, dis_b = 0, arm_a = 0, dis_a = 0, rd = 0;
    logic [1:0] mode = 0, src = 0;
    logic [31:0] wlen = 0;
    logic front_panel_event_input = 0, fire = 0;
    logic [7:0] hold = 3;
    // observed
    logic blk, t_o, act, armd, popen, cval;
    logic [31:0] cnt;
    int errors = 0, total_checks = 0, n_out = 0, nexp = 0;
    // burst cycle of the internal blocker edge: fire taken at 4, pin high from 5, two sync flops
    localparam int EDGE_AT = 7;
    // route the shared level to the chosen candidate only
    wire logic fp = (src == BSRC_FRONT_EVENT) & blk;
    wire logic sy = (src == BSRC_SYNC) & blk;
    wire logic [1:0] oth = {(src == BSRC_OTHER1) & blk, (src == BSRC_OTHER0) & blk};
    // 4 ns data clock
    initial forever #2 clk = ~clk;
    tbg_blk_model i_blk (.sys_clk_i(clk), .fire_i(fire), .hold_i(hold), .blk_o(blk));
    tbg_gate i_dut (.sys_clk_i(clk), .srst_i(srst), .configure_event_blocker_cmd_i(cfg_c),
        .arm_event_blocker_cmd_i(arm_b), .disarm_event_blocker_cmd_i(dis_b),
        .arm_acquisition_events_cmd_i(arm_a), .disarm_acquisition_events_cmd_i(dis_a),
        .read_blocker_pulse_count_cmd_i(rd), .cfg_mode_i(mode), .cfg_blocker_src_i(src),
        .cfg_window_len_i(wlen), .front_panel_event_input_pulse_i(front_panel_event_input), .front_panel_event_input_i(fp),
        .sync_input_i(sy), .other_src_i(oth), .front_panel_event_input_pulse_o(t_o), .blocking_active_o(act),
        .blocker_armed_o(armd), .pass_open_o(popen), .blocker_pulse_count_o(cnt),
        .count_valid_o(cval));
    // tally of passed triggers
    always @(posedge clk) if (t_o === 1'b1) n_out++;
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // one-cycle command pulse
    task automatic hit(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask : hit
    // trigger held high for span cycles, blocker fired at cycle 3
    task automatic burst(input int span, input bit f);
        n_out = 0;
        front_panel_event_input = 1;
        cyc(3);
        fire = f;
        cyc(1);
        fire = 0;
        cyc(span - 4);
        front_panel_event_input = 0;
        cyc(12); // long enough to flush the synchroniser
    endtask : burst
    // passes expected over a 40-cycle burst with the blocker fired
    function automatic int exp_n(input logic [1:0] md);
        case (md)
            MODE_ONCE: return 40 - EDGE_AT;
            MODE_WINDOW: return wlen;
            MODE_WINDOW_INV: return 40 - wlen;
            MODE_GATE: return hold;
            default: return -1;
        endcase
    endfunction : exp_n
    task end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // hang guard, far beyond the 910 or so cycles needed
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    // main sequence
    initial begin
        logic r;
        void'($urandom(32'h4b3a));
        cyc(20);
        srst = 0;
        cyc(1);
        `CHK("pass_open", 1'b1, popen)
        // unconfigured: random triggers pass, blocker ignored
        src = $urandom % 4;
        for (int i = 0; i < 60; i++) begin
            r = $urandom % 2;
            front_panel_event_input = r;
            fire = (i == 10);
            cyc(1);
            `CHK("front_panel_event_input_out", r, t_o)
        end
        front_panel_event_input = 0;
        for (int m = 0; m < 4; m++) begin
            mode = m;
            src = $urandom % 4;
            wlen = 2 + $urandom % 16;
            hold = 2 + $urandom % 8;
            hit(cfg_c);
            hit(arm_a);
            `CHK("active", 1'b1, act)
            burst(40, 1);
            `CHK("pre_arm", 0, n_out)
            hit(arm_b);
            `CHK("armed", 1'b1, armd)
            burst(40, 1);
            nexp++;
            if (m == MODE_ONCE)
                `CHK("once", exp_n(mode), n_out)
            else
                `CHK("passed", exp_n(mode), n_out)
            hit(rd);
            `CHK("cnt_valid", 1'b1, cval)
            `CHK("count", nexp, cnt)
            hit(dis_b);
            `CHK("disarmed", 1'b0, armd)
            burst(40, 1);
            `CHK("after_dis", 0, n_out)
            hit(arm_b);
            burst(20, 0);
            // no edge: the inverted window never opens and so passes all
            `CHK("rearm", (m == MODE_WINDOW_INV) ? 20 : 0, n_out)
        end
        // reception off: the armed gate must drop every trigger
        hit(dis_a);
        burst(40, 1);
        `CHK("acq_off", 0, n_out)
        end_sim();
    end
endmodule : trigger_blocking_gate_tb_top
`default_nettype wire
